// ### hw/fas_defines.svh
// Constants of the flash converter output sequencer
`ifndef FAS_DEFINES_SVH
`define FAS_DEFINES_SVH

// ****************************************
// Code format
// ****************************************
`define FAS_CODE_W        8
`define FAS_LEVEL_W       9
`define FAS_THRESH_COUNT  9'h100
`define FAS_CODE_ZERO     8'h00
`define FAS_CODE_MID      8'h80
`define FAS_CODE_FULL     8'hFF

// ****************************************
// Timing
// ****************************************
`define FAS_CLK_PERIOD_PS 5000
`define FAS_NEW_DATA_NS   20
`define FAS_NEW_DATA_CYC  ((`FAS_NEW_DATA_NS * 1000) / `FAS_CLK_PERIOD_PS)
`define FAS_PIPE_CYC      4

`endif

// ### hw/fas_pkg.sv
// Types of the flash converter output sequencer
package fas_pkg;
  typedef enum logic [0:0] {
    FAS_PH_LOW  = 1'b0,
    FAS_PH_HIGH = 1'b1
  } fas_phase_t;
  typedef logic [7:0] fas_code_t;
  typedef logic [8:0] fas_level_t;
endpackage

// ### hw/fas_sequencer.sv
// Flash converter output sequencer top level
`timescale 1ns/100ps
`include "fas_defines.svh"
module fas_sequencer
  import fas_pkg::*;
#(
  parameter int CODE_W       = `FAS_CODE_W,
  parameter int NEW_DATA_CYC = `FAS_NEW_DATA_CYC
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              clock_enable,
  // Conversion clock and analog level pins
  input  wire logic              conversion_clock,
  input  wire logic [8:0]        analog_level,
  // Output enable pins
  input  wire logic              enable_high,
  input  wire logic              enable_low_n,
  // Result bus pins
  output logic      [CODE_W-1:0] result_bus_out,
  output logic                   result_bus_oe,
  output logic                   overrange_flag,
  // Status
  output logic                   new_data_strobe,
  output logic                   result_valid
);
  fas_phase_t phase_ff;
  fas_phase_t nxt_phase;
  fas_level_t comp_ff;
  fas_level_t nxt_comp;
  fas_code_t  result_ff;
  fas_code_t  nxt_result;
  logic       over_ff;
  logic       nxt_over;
  logic       oe_ff;
  logic       nxt_oe;
  logic       strobe_ff;
  logic       nxt_strobe;
  logic       valid_ff;
  logic       nxt_valid;
  logic       clk_lvl;
  logic       nxt_clk_lvl;
  logic [8:0] lvl_sync;
  logic [8:0] nxt_lvl_sync;
  logic [1:0] en_sync;
  logic [1:0] nxt_en_sync;
  logic       rise;
  logic       fall;
  fas_code_t  conv_code;
  logic       conv_over;

  // ****************************************
  // Parameter checks
  // ****************************************
  generate
    if (CODE_W != `FAS_CODE_W) begin : g_chk_w
      $error("fas_sequencer serves only an eight bit code");
    end
    if (NEW_DATA_CYC < `FAS_PIPE_CYC) begin : g_chk_t
      $error("fas_sequencer cannot meet the new data delay");
    end
  endgenerate

  // ****************************************
  // Pin synchronisers
  // ****************************************
  fas_sync3 #(
    .WIDTH     (1),
    .RESET_VAL (32'h0000_0000)
  ) u_clk_sync (
    .clock        (clock),
    .reset        (reset),
    .clock_enable (clock_enable),
    .pin_in       (conversion_clock),
    .settled      (clk_lvl),
    .nxt_settled  (nxt_clk_lvl)
  );

  fas_sync3 #(
    .WIDTH     (9),
    .RESET_VAL (32'h0000_0000)
  ) u_lvl_sync (
    .clock        (clock),
    .reset        (reset),
    .clock_enable (clock_enable),
    .pin_in       (analog_level),
    .settled      (lvl_sync),
    .nxt_settled  (nxt_lvl_sync)
  );

  // Both enables start as if left open
  fas_sync3 #(
    .WIDTH     (2),
    .RESET_VAL (32'h0000_0003)
  ) u_en_sync (
    .clock        (clock),
    .reset        (reset),
    .clock_enable (clock_enable),
    .pin_in       ({enable_high, enable_low_n}),
    .settled      (en_sync),
    .nxt_settled  (nxt_en_sync)
  );

  // ****************************************
  // Conversion clock edges
  // ****************************************
  always_comb begin
    rise = clock_enable && !clk_lvl && nxt_clk_lvl;
    fall = clock_enable && clk_lvl && !nxt_clk_lvl;
  end

  // ****************************************
  // Quantizer
  // ****************************************
  always_comb begin
    conv_over = (comp_ff >= `FAS_THRESH_COUNT);
    if (comp_ff >= fas_level_t'({1'b0, `FAS_CODE_FULL})) begin
      conv_code = `FAS_CODE_FULL;
    end else begin
      conv_code = comp_ff[7:0];
    end
  end

  // ****************************************
  // Phase and latches, next values
  // ****************************************
  always_comb begin
    nxt_phase  = phase_ff;
    nxt_comp   = comp_ff;
    nxt_result = result_ff;
    nxt_over   = over_ff;
    nxt_strobe = strobe_ff;
    nxt_valid  = valid_ff;
    if (clock_enable) begin
      nxt_strobe = 1'b0;
      unique case (phase_ff)
        FAS_PH_HIGH: begin
          // Comparators follow, output latch closed
          nxt_comp = lvl_sync;
          if (fall) begin
            // Hold the level seen just before the edge
            nxt_comp   = comp_ff;
            // New code leaves on this same edge to meet the deadline
            nxt_result = conv_code;
            nxt_over   = conv_over;
            nxt_valid  = 1'b1;
            nxt_strobe = (conv_code != result_ff) || !valid_ff;
            nxt_phase  = FAS_PH_LOW;
          end
        end
        FAS_PH_LOW: begin
          // Comparators frozen, output latch transparent
          nxt_result = conv_code;
          nxt_over   = conv_over;
          nxt_valid  = 1'b1;
          nxt_strobe = (nxt_result != result_ff) || !valid_ff;
          if (rise) begin
            // Close output latch, release comparators
            nxt_result = result_ff;
            nxt_over   = over_ff;
            nxt_strobe = 1'b0;
            nxt_valid  = valid_ff;
            nxt_comp   = lvl_sync;
            nxt_phase  = FAS_PH_HIGH;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Phase and latches, registers
  // ****************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_ff  <= FAS_PH_LOW;
      comp_ff   <= '0;
      result_ff <= `FAS_CODE_ZERO;
      over_ff   <= 1'b0;
      strobe_ff <= 1'b0;
      valid_ff  <= 1'b0;
    end else begin
      phase_ff  <= nxt_phase;
      comp_ff   <= nxt_comp;
      result_ff <= nxt_result;
      over_ff   <= nxt_over;
      strobe_ff <= nxt_strobe;
      valid_ff  <= nxt_valid;
    end
  end

  // ****************************************
  // Output drivers, next values
  // ****************************************
  always_comb begin
    nxt_oe = oe_ff;
    if (clock_enable) begin
      nxt_oe = en_sync[1] && !en_sync[0];
    end
  end

  // ****************************************
  // Output drivers, registers
  // ****************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= nxt_oe;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign result_bus_out  = result_ff;
  assign result_bus_oe   = oe_ff;
  assign overrange_flag  = over_ff;
  assign new_data_strobe = strobe_ff;
  assign result_valid    = valid_ff;
endmodule

// ### hw/fas_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module fas_sync3 #(
  parameter int          WIDTH     = 1,
  parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             clock_enable,
  // Asynchronous pins
  input  wire logic [WIDTH-1:0] pin_in,
  // Filtered level
  output logic      [WIDTH-1:0] settled,
  output logic      [WIDTH-1:0] nxt_settled
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] settled_ff;
  logic [WIDTH-1:0] nxt_s1;
  logic [WIDTH-1:0] nxt_s2;
  logic [WIDTH-1:0] nxt_s3;

  generate
    if (WIDTH < 1 || WIDTH > 32) begin : g_chk
      $error("fas_sync3 needs WIDTH from one to 32");
    end
  endgenerate

  // ****************************************
  // Next values
  // ****************************************
  always_comb begin
    nxt_s1 = s1_ff;
    nxt_s2 = s2_ff;
    nxt_s3 = s3_ff;
    nxt_settled = settled_ff;
    if (clock_enable) begin
      nxt_s1 = pin_in;
      nxt_s2 = s1_ff;
      nxt_s3 = s2_ff;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          nxt_settled[i] = s3_ff[i];
        end
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_ff      <= RESET_VAL[WIDTH-1:0];
      s2_ff      <= RESET_VAL[WIDTH-1:0];
      s3_ff      <= RESET_VAL[WIDTH-1:0];
      settled_ff <= RESET_VAL[WIDTH-1:0];
    end else begin
      s1_ff      <= nxt_s1;
      s2_ff      <= nxt_s2;
      s3_ff      <= nxt_s3;
      settled_ff <= nxt_settled;
    end
  end

  assign settled = settled_ff;
endmodule

// ### verif/fas_bus_capture.sv
// Capture logic on the far side of the result bus
`timescale 1ns/100ps
module fas_bus_capture (
  // Clock
  input  wire logic       clock,
  // Converter side
  input  wire logic [7:0] drive_value,
  input  wire logic       drive_en,
  // Captured word
  output logic      [7:0] captured
);
  logic [7:0] last_ff;
  wire  [7:0] bus_wire;
  // Released bus shows the inverse of the last driven word
  assign bus_wire = drive_en ? drive_value : ~last_ff;
  always_ff @(posedge clock) begin
    if (drive_en) last_ff <= drive_value;
    captured <= bus_wire;
  end
endmodule

// ### verif/fas_seq_properties.sv
// Concurrent checks of the flash converter output sequencer
`timescale 1ns/100ps
module fas_seq_chk
  import fas_pkg::*;
#(
  parameter int CODE_W       = 8,
  parameter int NEW_DATA_CYC = 4
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              clock_enable,
  // Pins
  input wire logic              conversion_clock,
  input wire logic [8:0]        analog_level,
  input wire logic              enable_high,
  input wire logic              enable_low_n,
  // Results
  input wire logic [CODE_W-1:0] result_bus_out,
  input wire logic              result_bus_oe,
  input wire logic              overrange_flag,
  input wire logic              new_data_strobe
);
  fas_code_t exp_code;
  logic      bus_on;
  logic      rst_seen_ff;
  assign exp_code = (analog_level >= 9'h0FF) ? 8'hFF : analog_level[7:0];
  assign bus_on   = enable_high && !enable_low_n;
  // Masks the edge just after reset falls
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rst_seen_ff <= 1'b1;
    end else begin
      rst_seen_ff <= 1'b0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset || rst_seen_ff || !clock_enable);
  a_oe_on_enabled:
    assert property (bus_on[*5] |=> result_bus_oe)
      else $error("bus not driven");
  a_oe_off_disabled:
    assert property ((!bus_on)[*5] |=> !result_bus_oe)
      else $error("bus driven");
  a_oe_rise_cause:
    assert property ($rose(result_bus_oe) |->
      $past(enable_high, 4) && !$past(enable_low_n, 4))
      else $error("oe rose without enables");
  a_code_after_fall:
    assert property ($stable(analog_level)[*5] ##1 $fell(conversion_clock)
      |-> ##4 result_bus_out == $past(exp_code, 5)
      && overrange_flag == $past(analog_level[8], 5))
      else $error("wrong code after fall");
  a_hold_while_high:
    assert property (conversion_clock[*8] |=> $stable(result_bus_out)
      && $stable(overrange_flag) && !new_data_strobe)
      else $error("result moved while high");
  a_frozen_while_low:
    assert property ((!conversion_clock)[*8] |=>
      $stable(result_bus_out) && $stable(overrange_flag))
      else $error("result moved while low");
  a_strobe_one_cycle:
    assert property (new_data_strobe |=> !new_data_strobe)
      else $error("strobe too long");
  a_strobe_on_change:
    assert property ($changed(result_bus_out) |-> new_data_strobe)
      else $error("change without strobe");
  c_update: cover property ($fell(conversion_clock) ##4 new_data_strobe);
  c_overrange: cover property ($rose(overrange_flag));
  c_bus_off: cover property ($fell(result_bus_oe));
endmodule
bind fas_sequencer fas_seq_chk #(
  .CODE_W(CODE_W), .NEW_DATA_CYC(NEW_DATA_CYC)
) chk (
  .clock(clock), .reset(reset), .clock_enable(clock_enable),
  .conversion_clock(conversion_clock),
  .analog_level(analog_level), .enable_high(enable_high),
  .enable_low_n(enable_low_n), .result_bus_out(result_bus_out),
  .result_bus_oe(result_bus_oe), .overrange_flag(overrange_flag),
  .new_data_strobe(new_data_strobe)
);

// ### verif/tb_top.sv
// Self-checking testbench of the flash converter output sequencer
`timescale 1ns/100ps
module tb_top;
  import fas_pkg::*;
  logic        clock, reset, conversion_clock, enable_high, enable_low_n;
  logic        clock_enable;
  logic        result_bus_oe, overrange_flag, new_data_strobe, result_valid;
  fas_level_t  analog_level;
  fas_code_t   result_bus_out, captured;
  logic [15:0] lfsr;
  int          num_errors, checks_done, last_code;
  int          levels[$] = '{0, 1, 127, 128, 254, 255, 256, 300, 511};

  fas_sequencer dut (
    .clock(clock), .reset(reset), .clock_enable(clock_enable),
    .conversion_clock(conversion_clock), .analog_level(analog_level),
    .enable_high(enable_high), .enable_low_n(enable_low_n),
    .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe),
    .overrange_flag(overrange_flag), .new_data_strobe(new_data_strobe),
    .result_valid(result_valid)
  );
  fas_bus_capture partner (
    .clock(clock), .drive_value(result_bus_out),
    .drive_en(result_bus_oe), .captured(captured)
  );

  task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("mismatch %s exp %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // One conversion, then a level change while the result must stay frozen
  task automatic convert(int lvl, logic eh, logic eln);
    int code;
    code = (lvl >= 255) ? 255 : lvl;
    last_code = code;
    enable_high <= eh;
    enable_low_n <= eln;
    analog_level <= 9'(lvl);
    conversion_clock <= 1'b1;
    repeat (10) @(posedge clock);
    conversion_clock <= 1'b0;
    repeat (6) @(posedge clock);
    check("code", {1'b0, result_bus_out}, 9'(code));
    check("overrange", {8'h00, overrange_flag}, 9'(lvl >= 256));
    check("oe", {8'h00, result_bus_oe}, 9'(eh && !eln));
    check("valid", {8'h00, result_valid}, 9'h001);
    if (eh && !eln) check("bus", {1'b0, captured}, 9'(code));
    lfsr = lfsr_next(lfsr);
    analog_level <= lfsr[8:0];
    repeat (4) @(posedge clock);
    check("frozen", {1'b0, result_bus_out}, 9'(code));
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    #50000;
    num_errors++;
    finish_test();
  end

  initial begin
    num_errors = 0;
    checks_done = 0;
    lfsr = 16'hC399;
    clock_enable = 1'b1;
    reset = 1'b1;
    conversion_clock = 1'b0;
    analog_level = 9'h000;
    enable_high = 1'b1;
    enable_low_n = 1'b0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    foreach (levels[i]) convert(levels[i], !i[1], i[0]);
    $display("test levels done");
    reset <= 1'b1;
    @(posedge clock);
    check("reset oe", {8'h00, result_bus_oe}, 9'h000);
    check("reset flag", {8'h00, overrange_flag}, 9'h000);
    reset <= 1'b0;
    @(posedge clock);
    repeat (12) begin
      lfsr = lfsr_next(lfsr);
      convert(int'(lfsr[8:0]), lfsr[9], lfsr[10]);
    end
    $display("test random done");
    // A whole conversion while frozen must leave the result untouched
    clock_enable <= 1'b0;
    analog_level <= ~analog_level;
    conversion_clock <= 1'b1;
    repeat (10) @(posedge clock);
    conversion_clock <= 1'b0;
    repeat (6) @(posedge clock);
    check("freeze", {1'b0, result_bus_out}, 9'(last_code));
    clock_enable <= 1'b1;
    convert(200, 1'b1, 1'b0);
    $display("test freeze done");
    finish_test();
  end
endmodule
